// File: common/sector_map_pkg.sv
// package: register map, descriptor encodings and config-bit positions
package sector_map_pkg;

  // ***************************************************************
  // register offsets (byte addresses on the register bus)
  // ***************************************************************
  localparam logic [7:0] OFF_CFG_ONE   = 8'h00;
  localparam logic [7:0] OFF_CFG_THREE = 8'h04;
  localparam logic [7:0] OFF_ANY_ADDR  = 8'h08;
  localparam logic [7:0] OFF_ANY_DATA  = 8'h0C;
  localparam logic [7:0] OFF_DESC_SEL  = 8'h10;
  localparam logic [7:0] OFF_DESC_DATA = 8'h14;
  localparam logic [7:0] OFF_MAP_STAT  = 8'h18;

  // ***************************************************************
  // register reset values
  // ***************************************************************
  localparam logic [7:0]  RST_CFG_ONE   = 8'h00;
  localparam logic [7:0]  RST_CFG_THREE = 8'h02;
  localparam logic [31:0] RST_ANY_ADDR  = 32'h0000_0000;
  localparam logic [2:0]  RST_DESC_SEL  = 3'h0;

  // ***************************************************************
  // configuration bits that form the map index
  // ***************************************************************
  localparam int UNIFORM_ARCH_BIT = 3;
  localparam int PARAM_TOP_BIT    = 2;
  localparam int LARGE_256K_BIT   = 1;

  // read-any-register addresses of the two nonvolatile registers
  localparam logic [31:0] ANY_ADDR_CFG_ONE   = 32'h0000_0002;
  localparam logic [31:0] ANY_ADDR_CFG_THREE = 32'h0000_0004;

  // ***************************************************************
  // supported map index values
  // ***************************************************************
  localparam logic [2:0] IDX_HYBRID_BOTTOM = 3'h1;
  localparam logic [2:0] IDX_HYBRID_TOP    = 3'h3;
  localparam logic [2:0] IDX_UNIFORM_256K  = 3'h5;

  typedef enum logic [1:0] {
    MAP_BOTTOM,
    MAP_TOP,
    MAP_UNIFORM,
    MAP_UNSUPPORTED
  } map_sel_t;

  // map status register fields
  localparam int STAT_INDEX_LSB = 0;
  localparam int STAT_MAP_LSB   = 4;
  localparam int STAT_OK_BIT    = 8;

  // ***************************************************************
  // detection command descriptor encoding
  // ***************************************************************
  localparam logic [1:0] DESC_ADDR_LEN_VAR = 2'h3;
  localparam logic [1:0] DESC_RSV_HI       = 2'h3;
  localparam logic [3:0] DESC_LAT_VAR      = 4'hF;
  localparam logic [7:0] DESC_READ_ANY     = 8'h65;
  localparam logic [5:0] DESC_RSV_LO       = 6'h3F;
  localparam logic       DESC_IS_COMMAND   = 1'b0;

  localparam logic [7:0] MASK_DETECT_1 = 8'h08;
  localparam logic [7:0] MASK_DETECT_2 = 8'h04;
  localparam logic [7:0] MASK_DETECT_3 = 8'h02;
  localparam int         DESC_WORDS    = 6;

  typedef struct packed {
    logic [7:0] mask;
    logic [1:0] addr_len;
    logic [1:0] rsv_hi;
    logic [3:0] latency;
    logic [7:0] opcode;
    logic [5:0] rsv_lo;
    logic       kind;
    logic       last;
  } desc_t;

  // ***************************************************************
  // bus responses
  // ***************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : sector_map_pkg

// File: dv/detect_host.sv
// partner: register bus master and sector map detection host
`timescale 1ns/10ps
`default_nettype none
module detect_host (
  input  wire logic        aclk,
  output var  logic [7:0]  s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  output var  logic [7:0]  s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready
);
  // ****************************************
  // bus cycles
  // ****************************************
  int hang = 0;
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_wstrb = 4'hF;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    if (n == 64) hang++;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n == 64) hang++;
  endtask : rd
  // ****************************************
  // detection walk over the command descriptors
  // ****************************************
  // at most three commands, so a broken end flag cannot loop forever
  task automatic detect(output logic [2:0] idx, output logic ok);
    sector_map_pkg::desc_t dsc;
    logic [31:0] w;
    logic [31:0] v;
    logic [1:0]  r;
    logic [2:0]  s;
    idx = 3'h0;
    s = 3'h0;
    do
    begin
      wr(sector_map_pkg::OFF_DESC_SEL, {29'h0, s}, r);
      rd(sector_map_pkg::OFF_DESC_DATA, w, r);
      dsc = w;
      wr(sector_map_pkg::OFF_DESC_SEL, {29'h0, s + 3'h1}, r);
      rd(sector_map_pkg::OFF_DESC_DATA, w, r);
      wr(sector_map_pkg::OFF_ANY_ADDR, w, r);
      rd(sector_map_pkg::OFF_ANY_DATA, v, r);
      idx = {idx[1:0], |(v[7:0] & dsc.mask)};
      s = s + 3'h2;
    end
    while (dsc.kind == sector_map_pkg::DESC_IS_COMMAND && !dsc.last &&
           s < 3'h6);
    ok = idx inside {3'h1, 3'h3, 3'h5};
  endtask : detect
endmodule : detect_host
`default_nettype wire

// File: dv/sector_map_config_detect_tb.sv
// testbench: register access and detection of every map index combination
`timescale 1ns/10ps
`default_nettype none
module sector_map_config_detect_tb;
  logic        aclk, aresetn, map_supported, ok;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [2:0]  map_index, ix;
  int          bad_count = 0;
  int          comparisons = 0;
  localparam logic [31:0] DW [8] = '{32'h08FF65FC, 32'h4, 32'h04FF65FC,
    32'h2, 32'h02FF65FD, 32'h4, 32'hFFFFFFFF, 32'hFFFFFFFF};
  sector_map_config_detect sector_map_config_detect_inst (.*);
  detect_host detect_host_inst (.*);
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // ****************************************
  // compare and report
  // ****************************************
  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_data
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] t=%0t resp got=%h exp=%h", $time, g, e);
    end
  endtask : chk_resp
  task final_report;
    bad_count += detect_host_inst.hang;
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial
  begin
    #200us;
    bad_count++;
    final_report();
  end
  // a bus wait that ran out of cycles ends the run at once
  always @(detect_host_inst.hang)
  begin
    if (detect_host_inst.hang != 0)
      final_report();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    detect_host_inst.rd(sector_map_pkg::OFF_CFG_THREE, d, r);
    chk_data(d, 32'h02);
    chk_data({29'h0, map_index}, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      detect_host_inst.wr(sector_map_pkg::OFF_DESC_SEL, i, r);
      detect_host_inst.rd(sector_map_pkg::OFF_DESC_DATA, d, r);
      chk_data(d, DW[i]);
    end
    // other config bits set high so only the index bits may matter
    for (int i = 0; i < 8; i++)
    begin
      logic [2:0] k;
      logic       sup;
      k = i[2:0];
      sup = k inside {3'h1, 3'h3, 3'h5};
      detect_host_inst.wr(sector_map_pkg::OFF_CFG_THREE,
        {24'h0, 4'hF, k[2], 1'b1, k[0], 1'b1}, r);
      chk_resp(r, sector_map_pkg::RESP_OKAY);
      detect_host_inst.wr(sector_map_pkg::OFF_CFG_ONE,
        {24'h0, 5'h1F, k[1], 2'h3}, r);
      @(posedge aclk);
      #1;
      chk_data({29'h0, map_index}, {29'h0, k});
      chk_data({31'h0, map_supported}, {31'h0, sup});
      detect_host_inst.rd(sector_map_pkg::OFF_MAP_STAT, d, r);
      chk_data(d, {23'h0, sup, 2'h0, sup ? k[2:1] : 2'h3, 1'b0, k});
      detect_host_inst.detect(ix, ok);
      chk_data({29'h0, ix}, {29'h0, k});
      chk_data({31'h0, ok}, {31'h0, sup});
    end
    detect_host_inst.wr(8'h1C, 32'hFFFFFFFF, r);
    chk_resp(r, sector_map_pkg::RESP_SLVERR);
    detect_host_inst.rd(8'h1C, d, r);
    chk_resp(r, sector_map_pkg::RESP_SLVERR);
    chk_data(d, 32'h0);
    detect_host_inst.wr(sector_map_pkg::OFF_MAP_STAT, 32'h0, r);
    chk_resp(r, sector_map_pkg::RESP_OKAY);
    detect_host_inst.rd(sector_map_pkg::OFF_MAP_STAT, d, r);
    chk_data(d, 32'h37);
    detect_host_inst.wr(sector_map_pkg::OFF_ANY_ADDR, 32'h7, r);
    detect_host_inst.rd(sector_map_pkg::OFF_ANY_DATA, d, r);
    chk_data(d, 32'h0);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    detect_host_inst.rd(sector_map_pkg::OFF_CFG_ONE, d, r);
    chk_data(d, 32'h0);
    chk_data({29'h0, map_index}, 32'h1);
    final_report();
  end
endmodule : sector_map_config_detect_tb
`default_nettype wire

// File: dv/sector_map_props_properties.sv
// checker: port-level properties of the sector map detect block
`timescale 1ns/10ps
`default_nettype none
module sector_map_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [2:0]  map_index,
  input wire logic        map_supported
);
  // ****************************************
  // captured request fields
  // ****************************************
  logic [7:0] wa;
  logic [7:0] ra;
  logic [7:0] wd;
  logic       ws;
  logic [2:0] sel;
  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
    if (s_axi_wvalid && s_axi_wready) ws <= s_axi_wstrb[0];
    if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
  end
  // select mirrors the write that is applied as bvalid rises
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sel <= sector_map_pkg::RST_DESC_SEL;
    else if ($rose(s_axi_bvalid) && ws && wa == sector_map_pkg::OFF_DESC_SEL)
      sel <= wd[2:0];
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr(logic [7:0] off);
    $rose(s_axi_bvalid) && ws && wa == off;
  endsequence
  a_three_msb_lsb: assert property (
    s_wr(sector_map_pkg::OFF_CFG_THREE) |=>
      map_index[2] == wd[3] && map_index[0] == wd[1])
    else $error("index msb or lsb not from config three");
  a_one_mid_bit: assert property (
    s_wr(sector_map_pkg::OFF_CFG_ONE) |=> map_index[1] == wd[2])
    else $error("index middle bit not from config one");
  a_supported_set: assert property (
    map_supported == (map_index == 3'h1 || map_index == 3'h3 ||
      map_index == 3'h5))
    else $error("supported flag disagrees with index");
  a_desc_rsv_ones: assert property (
    s_axi_rvalid && ra == sector_map_pkg::OFF_DESC_DATA && !sel[0] &&
      sel < 3'h6 |-> s_axi_rdata[21:20] == 2'h3 &&
      s_axi_rdata[7:2] == 6'h3F && !s_axi_rdata[1])
    else $error("descriptor reserved fields not all ones");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule : sector_map_props
bind sector_map_config_detect sector_map_props sector_map_props_inst (.*);
`default_nettype wire

// File: verilog/sector_map_config_detect.sv
// design: sector map configuration registers and detection descriptors
`timescale 1ns/10ps
`default_nettype none

// What this block does
// RULE1 - host orders bits MSb first
// RULE2 - config three bit 3 is index MSb
// RULE3 - config one bit 2 is middle bit
// RULE4 - config three bit 1 is index LSb
// RULE5 - indices 1, 3, 5 name the maps
// RULE6 - software programs only supported combinations
// RULE7 - some bits become don't care
// RULE8 - detection uses read-any-register, variable fields
// RULE9 - first read targets address 4
// RULE10 - first read masked to bit 3
// RULE11 - second read masked to bit 2
// RULE12 - bit1 zero command, bit0 zero continue
// RULE13 - reserved descriptor fields read all ones
// RULE14 - third read targets address 4, last
// RULE15 - other indices flagged unsupported
module sector_map_config_detect #(
  parameter logic [7:0] CFG_ONE_INIT   = sector_map_pkg::RST_CFG_ONE,
  parameter logic [7:0] CFG_THREE_INIT = sector_map_pkg::RST_CFG_THREE
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [2:0]  map_index,
  output var  logic        map_supported
);

  // *************************************************************
  // descriptor table
  // *************************************************************
  function automatic logic [31:0] command_desc(input logic [7:0] mask,
                                               input logic       last);
    sector_map_pkg::desc_t d;
    d.mask     = mask;
    d.addr_len = sector_map_pkg::DESC_ADDR_LEN_VAR; // [RULE8]
    d.rsv_hi   = sector_map_pkg::DESC_RSV_HI;       // [RULE13]
    d.latency  = sector_map_pkg::DESC_LAT_VAR;      // [RULE8]
    d.opcode   = sector_map_pkg::DESC_READ_ANY;     // [RULE8]
    d.rsv_lo   = sector_map_pkg::DESC_RSV_LO;       // [RULE13]
    d.kind     = sector_map_pkg::DESC_IS_COMMAND;   // [RULE12]
    d.last     = last;
    return d;
  endfunction : command_desc

  function automatic logic [31:0] desc_word(input logic [2:0] sel);
    case (sel)
      3'h0:    desc_word = command_desc(sector_map_pkg::MASK_DETECT_1,
                                        1'b0);
      3'h1:    desc_word = sector_map_pkg::ANY_ADDR_CFG_THREE;
      3'h2:    desc_word = command_desc(sector_map_pkg::MASK_DETECT_2,
                                        1'b0);
      3'h3:    desc_word = sector_map_pkg::ANY_ADDR_CFG_ONE;
      3'h4:    desc_word = command_desc(sector_map_pkg::MASK_DETECT_3,
                                        1'b1);
      3'h5:    desc_word = sector_map_pkg::ANY_ADDR_CFG_THREE;
      default: desc_word = 32'hFFFF_FFFF;
    endcase
  endfunction : desc_word

  // *************************************************************
  // register state
  // *************************************************************
  logic [7:0]  nv_config_reg_one;
  logic [7:0]  nv_config_reg_three;
  logic [31:0] any_addr;
  logic [2:0]  desc_sel;

  // write channel holding
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;

  logic [2:0]              next_index;
  sector_map_pkg::map_sel_t next_map;
  logic                    next_ok;

  // *************************************************************
  // map index from the device's own configuration
  // *************************************************************
  always_comb
  begin
    next_index = {nv_config_reg_three[sector_map_pkg::UNIFORM_ARCH_BIT],
                  nv_config_reg_one[sector_map_pkg::PARAM_TOP_BIT],
                  nv_config_reg_three[sector_map_pkg::LARGE_256K_BIT]};
    // [RULE2] [RULE3] [RULE4]
    case (next_index)
      sector_map_pkg::IDX_HYBRID_BOTTOM: next_map = sector_map_pkg::MAP_BOTTOM;
      sector_map_pkg::IDX_HYBRID_TOP:    next_map = sector_map_pkg::MAP_TOP;
      sector_map_pkg::IDX_UNIFORM_256K:  next_map =
                                           sector_map_pkg::MAP_UNIFORM;
      default:                           next_map =
                                           sector_map_pkg::MAP_UNSUPPORTED;
    endcase
    next_ok = (next_map != sector_map_pkg::MAP_UNSUPPORTED);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      map_index     <= 3'h0;
      map_supported <= 1'b0;
    end
    else
    begin
      map_index     <= next_index;
      map_supported <= next_ok;
    end
  end

  // *************************************************************
  // write address and data, taken in either order
  // *************************************************************
  // ready drops while a channel is held, so a second item waits
  // until the response has been accepted
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      aw_addr       <= 8'h00;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else if (do_write)
    begin
      w_held <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !w_held && !s_axi_bvalid;
    end
  end

  // *************************************************************
  // register updates
  // *************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nv_config_reg_one   <= CFG_ONE_INIT;
      nv_config_reg_three <= CFG_THREE_INIT;
      any_addr            <= sector_map_pkg::RST_ANY_ADDR;
      desc_sel            <= sector_map_pkg::RST_DESC_SEL;
    end
    else if (do_write)
    begin
      case (aw_addr)
        sector_map_pkg::OFF_CFG_ONE:
          if (w_strb[0])
            nv_config_reg_one <= w_data[7:0];
        sector_map_pkg::OFF_CFG_THREE:
          if (w_strb[0])
            nv_config_reg_three <= w_data[7:0];
        sector_map_pkg::OFF_ANY_ADDR:
          for (int b = 0; b < 4; b++)
            if (w_strb[b])
              any_addr[8*b +: 8] <= w_data[8*b +: 8];
        sector_map_pkg::OFF_DESC_SEL:
          if (w_strb[0])
            desc_sel <= w_data[2:0];
        default:
          ;
      endcase
    end
  end

  // *************************************************************
  // write response
  // *************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sector_map_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr)
        sector_map_pkg::OFF_CFG_ONE,
        sector_map_pkg::OFF_CFG_THREE,
        sector_map_pkg::OFF_ANY_ADDR,
        sector_map_pkg::OFF_DESC_SEL,
        sector_map_pkg::OFF_ANY_DATA,
        sector_map_pkg::OFF_DESC_DATA,
        sector_map_pkg::OFF_MAP_STAT:
          s_axi_bresp <= sector_map_pkg::RESP_OKAY;
        default:
          s_axi_bresp <= sector_map_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // *************************************************************
  // read channel
  // *************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= sector_map_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= sector_map_pkg::RESP_OKAY;
      case (s_axi_araddr)
        sector_map_pkg::OFF_CFG_ONE:
          s_axi_rdata <= {24'h000000, nv_config_reg_one};
        sector_map_pkg::OFF_CFG_THREE:
          s_axi_rdata <= {24'h000000, nv_config_reg_three};
        sector_map_pkg::OFF_ANY_ADDR:
          s_axi_rdata <= any_addr;
        // read-any-register path the detection commands use
        sector_map_pkg::OFF_ANY_DATA:
          if (any_addr == sector_map_pkg::ANY_ADDR_CFG_ONE)
            s_axi_rdata <= {24'h000000, nv_config_reg_one};
          else if (any_addr == sector_map_pkg::ANY_ADDR_CFG_THREE)
            s_axi_rdata <= {24'h000000, nv_config_reg_three};
          else
            s_axi_rdata <= 32'h0000_0000;
        sector_map_pkg::OFF_DESC_SEL:
          s_axi_rdata <= {29'h00000000, desc_sel};
        sector_map_pkg::OFF_DESC_DATA:
          s_axi_rdata <= desc_word(desc_sel); // [RULE13]
        sector_map_pkg::OFF_MAP_STAT:
          s_axi_rdata <= {23'h000000, map_supported, 2'h0, next_map,
                          1'b0, map_index};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= sector_map_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
    begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : sector_map_config_detect

`default_nettype wire
